/* tb_top.sv */
// Testbench for the flag and divisor block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ufbd_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hf;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic [4:0]  s_tx = 5'h00, s_rx = 5'h00;
    logic        s_busy = 1'b0, s_idle = 1'b1, s_cts_n = 1'b1;
    wire logic   awready, wready, bvalid, arready, rvalid, fifo_enable, baud_tick, irq;
    wire logic   tx_shift_busy, line_idle, cts_n;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [4:0]  tx_lvl, rx_lvl;
    int          n_errors = 0, checked = 0, cycles = 0, n, s;
    localparam logic [31:0] FM = 32'hffff_fef9;
    ufbd_top #(.FIFO_DEPTH(16)) u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .tx_fifo_level(tx_lvl),
        .rx_fifo_level(rx_lvl), .tx_shift_busy(tx_shift_busy), .line_idle(line_idle),
        .clear_to_send_n_pin(cts_n), .fifo_enable(fifo_enable), .baud_tick(baud_tick),
        .irq(irq));
    ufbd_xcvr_model #(.LEVEL_W(5)) u_model (.aclk(aclk), .fifo_enable(fifo_enable),
        .set_tx(s_tx), .set_rx(s_rx), .set_busy(s_busy), .set_idle(s_idle),
        .set_cts_n(s_cts_n), .tx_fifo_level(tx_lvl), .rx_fifo_level(rx_lvl),
        .tx_shift_busy(tx_shift_busy), .line_idle(line_idle), .clear_to_send_n_pin(cts_n));
    initial forever #4 aclk = ~aclk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge aclk); while (!bvalid);
        check("bresp", {30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        check(nm, rdata & m, e);
        check("rresp", {30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
    endtask
    task automatic gap(output int g);
        g = 0;
        do begin
            @(posedge aclk);
            g++;
        end while (!baud_tick);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_flags();
        logic [12:0] cs [5] = '{13'b0_00000_00000_1_1, 13'b0_00001_00001_0_0,
            13'b1_00001_01111_0_1, 13'b1_10000_10000_0_0, 13'b1_00000_10000_1_1};
        logic [4:0] tl, rl;
        logic fe;
        for (int i = 0; i < 5; i++) begin
            {fe, tl, rl} = cs[i][12:2];
            wchk(UFBD_OFS_CTRL, {31'h0, fe}, UFBD_RESP_OKAY);
            check("fifo_enable", {31'h0, fifo_enable}, {31'h0, fe});
            s_tx <= tl;
            s_rx <= rl;
            s_busy <= cs[i][1];
            s_cts_n <= cs[i][0];
            repeat (3) @(posedge aclk);
            rchk("flags", UFBD_OFS_FLAGS, FM, {24'h0, tl == 0, fe ? rl == 16 : rl != 0,
                fe ? tl == 16 : tl != 0, rl == 0, tl != 0 || cs[i][1], 2'b00,
                !cs[i][0]}, UFBD_RESP_OKAY);
        end
        s_tx <= 5'h00;
        s_rx <= 5'h00;
        s_busy <= 1'b0;
        s_cts_n <= 1'b1;
        wchk(UFBD_OFS_CTRL, 32'h0, UFBD_RESP_OKAY);
        $display("flags test done");
    endtask
    task automatic t_regs();
        rchk("int", UFBD_OFS_DIV_INT, '1, 32'h0, UFBD_RESP_OKAY);
        rchk("frac", UFBD_OFS_DIV_FRAC, '1, 32'h0, UFBD_RESP_OKAY);
        rchk("flags", UFBD_OFS_FLAGS, FM, 32'h90, UFBD_RESP_OKAY);
        wchk(UFBD_OFS_DIV_INT, 32'hffff_ffff, UFBD_RESP_OKAY);
        rchk("int", UFBD_OFS_DIV_INT, '1, 32'h0000_ffff, UFBD_RESP_OKAY);
        wchk(UFBD_OFS_DIV_FRAC, 32'hffff_ffff, UFBD_RESP_OKAY);
        rchk("frac", UFBD_OFS_DIV_FRAC, '1, 32'h3f, UFBD_RESP_OKAY);
        wchk(UFBD_OFS_IRDA, 32'hffff_ffff, UFBD_RESP_OKAY);
        rchk("irda", UFBD_OFS_IRDA, '1, 32'h0, UFBD_RESP_OKAY);
        wchk(8'h40, 32'h1, UFBD_RESP_SLVERR);
        rchk("unmapped", 8'h40, '1, 32'h0, UFBD_RESP_SLVERR);
        $display("register test done");
    endtask
    task automatic t_tick();
        wchk(UFBD_OFS_DIV_FRAC, 32'h0, UFBD_RESP_OKAY);
        wchk(UFBD_OFS_DIV_INT, 32'h3, UFBD_RESP_OKAY);
        gap(n);
        gap(n);
        check("gap", n, 32'd3);
        wchk(UFBD_OFS_DIV_FRAC, 32'h10, UFBD_RESP_OKAY);
        gap(n);
        s = 0;
        repeat (4) begin
            gap(n);
            s += n;
        end
        check("four gaps", s, 32'd13);
        wchk(UFBD_OFS_DIV_FRAC, 32'h0, UFBD_RESP_OKAY);
        gap(n);
        s_idle <= 1'b0;
        wchk(UFBD_OFS_DIV_INT, 32'h5, UFBD_RESP_OKAY);
        gap(n);
        gap(n);
        check("gap busy line", n, 32'd3);
        s_idle <= 1'b1;
        gap(n);
        gap(n);
        check("gap idle line", n, 32'd5);
        wchk(UFBD_OFS_DIV_INT, 32'h0, UFBD_RESP_OKAY);
        $display("tick test done");
    endtask
    task automatic t_irq();
        rchk("status", UFBD_OFS_IRQ_STAT, 32'h0, 32'h0, UFBD_RESP_OKAY);
        rchk("status cleared", UFBD_OFS_IRQ_STAT, '1, 32'h0, UFBD_RESP_OKAY);
        wchk(UFBD_OFS_IRQ_MASK, 32'h1, UFBD_RESP_OKAY);
        s_tx <= 5'h01;
        repeat (3) @(posedge aclk);
        s_tx <= 5'h00;
        repeat (3) @(posedge aclk);
        check("irq", {31'h0, irq}, 32'h1);
        rchk("status", UFBD_OFS_IRQ_STAT, '1, 32'h1, UFBD_RESP_OKAY);
        repeat (2) @(posedge aclk);
        check("irq", {31'h0, irq}, 32'h0);
        wchk(UFBD_OFS_IRQ_MASK, 32'h0, UFBD_RESP_OKAY);
        s_cts_n <= 1'b0;
        repeat (3) @(posedge aclk);
        check("irq masked", {31'h0, irq}, 32'h0);
        rchk("status", UFBD_OFS_IRQ_STAT, '1, 32'h4, UFBD_RESP_OKAY);
        s_cts_n <= 1'b1;
        $display("interrupt test done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            results();
        end
    end
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_flags();
        t_tick();
        t_irq();
        results();
    end
endmodule
`default_nettype wire

/* ufbd_pkg.sv */
// Constants for the serial flag and baud divisor block
package ufbd_pkg;
    localparam int          UFBD_ADDR_W        = 8;
    localparam int          UFBD_DATA_W        = 32;
    // Register byte offsets
    localparam logic [7:0]  UFBD_OFS_FLAGS     = 8'h00;
    localparam logic [7:0]  UFBD_OFS_IRDA      = 8'h04;
    localparam logic [7:0]  UFBD_OFS_DIV_INT   = 8'h08;
    localparam logic [7:0]  UFBD_OFS_DIV_FRAC  = 8'h0c;
    localparam logic [7:0]  UFBD_OFS_CTRL      = 8'h10;
    localparam logic [7:0]  UFBD_OFS_IRQ_STAT  = 8'h14;
    localparam logic [7:0]  UFBD_OFS_IRQ_MASK  = 8'h18;
    // Flag register bit positions
    localparam int          UFBD_FLAG_CTS      = 0;
    localparam int          UFBD_FLAG_BUSY     = 3;
    localparam int          UFBD_FLAG_RX_EMPTY = 4;
    localparam int          UFBD_FLAG_TX_FULL  = 5;
    localparam int          UFBD_FLAG_RX_FULL  = 6;
    localparam int          UFBD_FLAG_TX_EMPTY = 7;
    // Field widths
    localparam int          UFBD_INT_W         = 16;
    localparam int          UFBD_FRAC_W        = 6;
    localparam int          UFBD_OVERSAMPLE    = 16;
    // Control register bit positions
    localparam int          UFBD_CTRL_FIFO_EN  = 0;
    // Interrupt status and mask bit positions
    localparam int          UFBD_IRQ_TX_EMPTY  = 0;
    localparam int          UFBD_IRQ_RX_DATA   = 1;
    localparam int          UFBD_IRQ_CTS       = 2;
    localparam int          UFBD_IRQ_W         = 3;
    // Reset values
    localparam logic [15:0] UFBD_RST_DIV_INT   = 16'h0000;
    localparam logic [5:0]  UFBD_RST_DIV_FRAC  = 6'h00;
    localparam logic        UFBD_RST_FIFO_EN   = 1'b0;
    localparam logic [2:0]  UFBD_RST_IRQ_MASK  = 3'h0;
    localparam logic        UFBD_RST_TX_EMPTY  = 1'b1;
    // Bus responses
    localparam logic [1:0]  UFBD_RESP_OKAY     = 2'b00;
    localparam logic [1:0]  UFBD_RESP_SLVERR   = 2'b10;
endpackage

/* ufbd_props.sv */
// Checker for the flag and divisor block
`timescale 1ns/1ps
`default_nettype none
module ufbd_props
    import ufbd_pkg::*;
#(
    parameter int FIFO_DEPTH = 16,
    parameter int LEVEL_W    = 5
) (
    input wire logic               aclk,
    input wire logic               aresetn,
    input wire logic [7:0]         araddr,
    input wire logic               arvalid,
    input wire logic               arready,
    input wire logic [31:0]        rdata,
    input wire logic [1:0]         bresp,
    input wire logic               bvalid,
    input wire logic               bready,
    input wire logic [LEVEL_W-1:0] tx_fifo_level,
    input wire logic [LEVEL_W-1:0] rx_fifo_level,
    input wire logic               tx_shift_busy,
    input wire logic               clear_to_send_n_pin,
    input wire logic               fifo_enable,
    input wire logic               baud_tick
);
    wire logic rd_take = arvalid && arready;
    wire logic rd_flg  = rd_take && (araddr == UFBD_OFS_FLAGS);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_tx_empty:
        assert property (rd_flg |=> rdata[7] == ($past(tx_fifo_level) == 0))
        else $error("tx empty flag wrong");
    a_rx_full:
        assert property (rd_flg |=> rdata[6] == ($past(fifo_enable) ?
            $past(rx_fifo_level) == FIFO_DEPTH : $past(rx_fifo_level) != 0))
        else $error("rx full flag wrong");
    a_tx_full:
        assert property (rd_flg |=> rdata[5] == ($past(fifo_enable) ?
            $past(tx_fifo_level) == FIFO_DEPTH : $past(tx_fifo_level) != 0))
        else $error("tx full flag wrong");
    a_rx_empty:
        assert property (rd_flg |=> rdata[4] == ($past(rx_fifo_level) == 0))
        else $error("rx empty flag wrong");
    a_busy_flag:
        assert property (rd_flg |=> rdata[3] ==
            ($past(tx_fifo_level) != 0 || $past(tx_shift_busy)))
        else $error("busy flag wrong");
    a_cts_flag:
        assert property (rd_flg |=> rdata[0] == !$past(clear_to_send_n_pin))
        else $error("clear to send flag wrong");
    a_irda_zero:
        assert property (rd_take && araddr == UFBD_OFS_IRDA |=> rdata == 32'h0)
        else $error("infrared register not zero");
    a_bresp_hold:
        assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    c_tick: cover property (baud_tick);
    c_fifo_rd: cover property (rd_flg && fifo_enable);
    c_shift_only: cover property (rd_flg && tx_shift_busy && tx_fifo_level == 0);
endmodule
bind ufbd_top ufbd_props #(.FIFO_DEPTH(FIFO_DEPTH), .LEVEL_W(LEVEL_W)) u_props (
    .aclk(aclk), .aresetn(aresetn), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .tx_fifo_level(tx_fifo_level), .rx_fifo_level(rx_fifo_level),
    .tx_shift_busy(tx_shift_busy), .clear_to_send_n_pin(clear_to_send_n_pin),
    .fifo_enable(fifo_enable), .baud_tick(baud_tick));
`default_nettype wire

/* ufbd_top.sv */
// Flag register, baud divisor and 16x tick generator behind AXI4-Lite
//
// What this block does
// R1 - Transmit-empty bit 7 shows holding register or FIFO empty; resets to one.
// R2 - Transmit-empty ignores the shift register; only queue occupancy counts.
// R3 - Receive-full bit 6 shows holding register full or FIFO full.
// R4 - Transmit-full bit 5 shows holding register full or FIFO full.
// R5 - Receive-empty bit 4 shows holding register empty or FIFO empty.
// R6 - Busy bit 3 stays set until the last stop bit has left.
// R7 - Busy sets once the transmit FIFO holds anything, enabled or not.
// R8 - Bit 0 reads the inverse of the active-low clear-to-send pin.
// R9 - Ring, carrier and data-set-ready bits unused; write zero, read meaningless.
// R10 - Infrared register ignores writes and always reads zero.
// R11 - Integer divisor is sixteen bits read/write, resets to zero.
// R12 - Fractional divisor is six bits read/write, resets to zero.
// R13 - Divisor equals reference clock over sixteen times line rate.
// R14 - New divisor values apply only once the current character ends.
// R15 - FIFO enable clear makes both queues single-entry holding registers.
// R16 - Fraction counts sixty-fourths, accumulated every tick period.
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module ufbd_top
    import ufbd_pkg::*;
#(
    parameter int FIFO_DEPTH = 16,
    parameter int LEVEL_W    = $clog2(FIFO_DEPTH + 1)
) (
    // Clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,

    // Write address
    input  wire logic [UFBD_ADDR_W-1:0] awaddr,
    input  wire logic                   awvalid,
    output logic                        awready,

    // Write data
    input  wire logic [31:0]            wdata,
    input  wire logic [3:0]             wstrb,
    input  wire logic                   wvalid,
    output logic                        wready,

    // Write response
    output logic [1:0]                  bresp,
    output logic                        bvalid,
    input  wire logic                   bready,

    // Read address
    input  wire logic [UFBD_ADDR_W-1:0] araddr,
    input  wire logic                   arvalid,
    output logic                        arready,

    // Read data
    output logic [31:0]                 rdata,
    output logic [1:0]                  rresp,
    output logic                        rvalid,
    input  wire logic                   rready,

    // Rest of the transceiver
    input  wire logic [LEVEL_W-1:0]     tx_fifo_level,
    input  wire logic [LEVEL_W-1:0]     rx_fifo_level,
    input  wire logic                   tx_shift_busy,
    input  wire logic                   line_idle,
    input  wire logic                   clear_to_send_n_pin,

    // Control and event outputs
    output logic                        fifo_enable,
    output logic                        baud_tick,
    output logic                        irq
);

    ////////////////////////////////////////////////////////////////////////
    // Flag computation
    logic                   tx_empty_flag;
    logic                   tx_full_flag;
    logic                   rx_empty_flag;
    logic                   rx_full_flag;
    logic                   busy_flag;
    logic                   cts_flag;
    logic [LEVEL_W-1:0]     full_level;
    logic [31:0]            flags_word;

    // R15 queue depth by mode
    assign full_level    = fifo_enable ? LEVEL_W'(FIFO_DEPTH) : LEVEL_W'(1);
    // R1 R2 transmit empty from occupancy only
    assign tx_empty_flag = (tx_fifo_level == '0);

    // R4 transmit full
    assign tx_full_flag  = (tx_fifo_level >= full_level);

    // R5 receive empty
    assign rx_empty_flag = (rx_fifo_level == '0);

    // R3 receive full
    assign rx_full_flag  = (rx_fifo_level >= full_level);

    // R6 R7 busy while queued or shifting
    assign busy_flag     = !tx_empty_flag || tx_shift_busy;

    // R8 inverted clear-to-send
    assign cts_flag      = !clear_to_send_n_pin;

    // R9 unused modem bits read zero
    always_comb begin
        flags_word                     = 32'h0000_0000;
        flags_word[UFBD_FLAG_TX_EMPTY] = tx_empty_flag;
        flags_word[UFBD_FLAG_RX_FULL]  = rx_full_flag;
        flags_word[UFBD_FLAG_TX_FULL]  = tx_full_flag;
        flags_word[UFBD_FLAG_RX_EMPTY] = rx_empty_flag;
        flags_word[UFBD_FLAG_BUSY]     = busy_flag;
        flags_word[UFBD_FLAG_CTS]      = cts_flag;
    end

    ////////////////////////////////////////////////////////////////////////
    // Write channel
    logic                   aw_held;
    logic                   w_held;
    logic [UFBD_ADDR_W-1:0] wr_addr;
    logic [31:0]            wr_data;
    logic [3:0]             wr_strb;
    logic                   do_write;
    logic                   wr_mapped;
    logic [UFBD_INT_W-1:0]  div_int;
    logic [UFBD_FRAC_W-1:0] div_frac;
    logic [UFBD_IRQ_W-1:0]  irq_mask;

    assign do_write  = aw_held && w_held && !bvalid;

    // Address decode of the held write
    logic                   wr_hit_flags;
    logic                   wr_hit_irda;
    logic                   wr_hit_int;
    logic                   wr_hit_frac;
    logic                   wr_hit_ctrl;
    logic                   wr_hit_stat;
    logic                   wr_hit_mask;
    assign wr_hit_flags = (wr_addr == UFBD_OFS_FLAGS);
    assign wr_hit_irda  = (wr_addr == UFBD_OFS_IRDA);
    assign wr_hit_int   = (wr_addr == UFBD_OFS_DIV_INT);
    assign wr_hit_frac  = (wr_addr == UFBD_OFS_DIV_FRAC);
    assign wr_hit_ctrl  = (wr_addr == UFBD_OFS_CTRL);
    assign wr_hit_stat  = (wr_addr == UFBD_OFS_IRQ_STAT);
    assign wr_hit_mask  = (wr_addr == UFBD_OFS_IRQ_MASK);
    assign wr_mapped    = wr_hit_flags || wr_hit_irda || wr_hit_int || wr_hit_frac
                       || wr_hit_ctrl || wr_hit_stat || wr_hit_mask;

    // Write address capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            awready <= 1'b1;
            wr_addr <= '0;
        end else if (awvalid && awready) begin
            aw_held <= 1'b1;
            awready <= 1'b0;
            wr_addr <= awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end else if (bvalid && bready) begin
            awready <= 1'b1;
        end
    end

    // Write data capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held  <= 1'b0;
            wready  <= 1'b1;
            wr_data <= '0;
            wr_strb <= '0;
        end else if (wvalid && wready) begin
            w_held  <= 1'b1;
            wready  <= 1'b0;
            wr_data <= wdata;
            wr_strb <= wstrb;
        end else if (do_write) begin
            w_held  <= 1'b0;
        end else if (bvalid && bready) begin
            wready  <= 1'b1;
        end
    end

    // Write response, held until taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= UFBD_RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp  <= wr_mapped ? UFBD_RESP_OKAY : UFBD_RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // R10 infrared offset has no storage; writes there fall through
    // R11 integer divisor storage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_int <= UFBD_RST_DIV_INT;
        end else if (do_write && wr_addr == UFBD_OFS_DIV_INT) begin
            // Low byte lane
            if (wr_strb[0]) begin
                div_int[7:0] <= wr_data[7:0];
            end
            // High byte lane
            if (wr_strb[1]) begin
                div_int[15:8] <= wr_data[15:8];
            end
        end
    end

    // R12 fractional divisor storage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_frac <= UFBD_RST_DIV_FRAC;
        end else if (do_write && wr_addr == UFBD_OFS_DIV_FRAC && wr_strb[0]) begin
            div_frac <= wr_data[UFBD_FRAC_W-1:0];
        end
    end

    // Control bit and interrupt mask
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fifo_enable <= UFBD_RST_FIFO_EN;
            irq_mask    <= UFBD_RST_IRQ_MASK;
        end else if (do_write && wr_strb[0]) begin
            if (wr_addr == UFBD_OFS_CTRL) begin
                fifo_enable <= wr_data[UFBD_CTRL_FIFO_EN];
            end
            if (wr_addr == UFBD_OFS_IRQ_MASK) begin
                irq_mask <= wr_data[UFBD_IRQ_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status
    logic                   prev_tx_empty;
    logic                   prev_rx_empty;
    logic                   prev_cts;
    logic [UFBD_IRQ_W-1:0]  irq_status;
    logic [UFBD_IRQ_W-1:0]  irq_set;
    logic [UFBD_IRQ_W-1:0]  next_irq_status;
    logic                   status_read;

    // Transmit queue drained
    assign irq_set[UFBD_IRQ_TX_EMPTY] = tx_empty_flag && !prev_tx_empty;
    // Receive queue got data
    assign irq_set[UFBD_IRQ_RX_DATA]  = !rx_empty_flag && prev_rx_empty;
    // Either edge of clear-to-send
    assign irq_set[UFBD_IRQ_CTS]      = cts_flag != prev_cts;

    assign status_read     = arvalid && arready && (araddr == UFBD_OFS_IRQ_STAT);
    // A new event in the reading cycle survives the clear
    assign next_irq_status = (status_read ? '0 : irq_status) | irq_set;

    // Edge history, sticky status and registered request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_tx_empty <= UFBD_RST_TX_EMPTY;
            prev_rx_empty <= 1'b1;
            prev_cts      <= 1'b0;
            irq_status    <= '0;
            irq           <= 1'b0;
        end else begin
            prev_tx_empty <= tx_empty_flag;
            prev_rx_empty <= rx_empty_flag;
            prev_cts      <= cts_flag;
            irq_status    <= next_irq_status;
            irq           <= |(next_irq_status & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel
    logic [31:0]            rd_mux;
    logic                   rd_mapped;

    // Address decode of the offered read
    logic                   rd_hit_flags;
    logic                   rd_hit_irda;
    logic                   rd_hit_int;
    logic                   rd_hit_frac;
    logic                   rd_hit_ctrl;
    logic                   rd_hit_stat;
    logic                   rd_hit_mask;
    assign rd_hit_flags = (araddr == UFBD_OFS_FLAGS);
    assign rd_hit_irda  = (araddr == UFBD_OFS_IRDA);
    assign rd_hit_int   = (araddr == UFBD_OFS_DIV_INT);
    assign rd_hit_frac  = (araddr == UFBD_OFS_DIV_FRAC);
    assign rd_hit_ctrl  = (araddr == UFBD_OFS_CTRL);
    assign rd_hit_stat  = (araddr == UFBD_OFS_IRQ_STAT);
    assign rd_hit_mask  = (araddr == UFBD_OFS_IRQ_MASK);

    // R10 infrared offset reads zero
    assign rd_mux = rd_hit_flags ? flags_word
                  : rd_hit_int   ? {16'h0000, div_int}
                  : rd_hit_frac  ? {26'h0000000, div_frac}
                  : rd_hit_ctrl  ? {31'h00000000, fifo_enable}
                  : rd_hit_stat  ? {29'h00000000, irq_status}
                  : rd_hit_mask  ? {29'h00000000, irq_mask}
                  : 32'h0000_0000;
    assign rd_mapped = rd_hit_flags || rd_hit_irda || rd_hit_int || rd_hit_frac
                    || rd_hit_ctrl || rd_hit_stat || rd_hit_mask;

    // Read response, held until taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= UFBD_RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_mux;
            rresp   <= rd_mapped ? UFBD_RESP_OKAY : UFBD_RESP_SLVERR;
        end else if (rvalid && rready) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Oversampling tick generator
    logic [UFBD_INT_W-1:0]  act_int;
    logic [UFBD_FRAC_W-1:0] act_frac;
    logic [UFBD_INT_W-1:0]  tick_count;
    logic [UFBD_FRAC_W-1:0] frac_acc;
    logic                   extra_cycle;
    logic [UFBD_FRAC_W:0]   frac_sum;
    logic [UFBD_INT_W:0]    period_len;
    logic [UFBD_INT_W:0]    count_plus;
    logic                   period_end;

    // R13 period of int + frac/64 reference cycles gives 16x line rate
    assign period_len = {1'b0, act_int} + {{UFBD_INT_W{1'b0}}, extra_cycle};
    assign count_plus = {1'b0, tick_count} + {{UFBD_INT_W{1'b0}}, 1'b1};
    assign period_end = (act_int != '0) && (count_plus >= period_len);
    // R16 sixty-fourths accumulate, carry lengthens next period
    assign frac_sum   = {1'b0, frac_acc} + {1'b0, act_frac};

    // R14 divisor copies update only between characters
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            act_int  <= UFBD_RST_DIV_INT;
            act_frac <= UFBD_RST_DIV_FRAC;
        end else if (line_idle) begin
            act_int  <= div_int;
            act_frac <= div_frac;
        end
    end

    // Period counter and tick pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_count  <= '0;
            frac_acc    <= '0;
            extra_cycle <= 1'b0;
            baud_tick   <= 1'b0;
        end else if (period_end) begin
            tick_count  <= '0;
            frac_acc    <= frac_sum[UFBD_FRAC_W-1:0];
            extra_cycle <= frac_sum[UFBD_FRAC_W];
            baud_tick   <= 1'b1;
        end else begin
            // Count up within the period; a zero divisor parks the counter
            tick_count  <= (act_int == '0) ? '0 : count_plus[UFBD_INT_W-1:0];
            baud_tick   <= 1'b0;
        end
    end

endmodule
`default_nettype wire

/* ufbd_xcvr_model.sv */
// Model of the transceiver around the block: queues, shifter, line and pin
`timescale 1ns/1ps
`default_nettype none
module ufbd_xcvr_model #(
    parameter int LEVEL_W = 5
) (
    input  wire logic               aclk,
    input  wire logic               fifo_enable,
    input  wire logic [LEVEL_W-1:0] set_tx,
    input  wire logic [LEVEL_W-1:0] set_rx,
    input  wire logic               set_busy,
    input  wire logic               set_idle,
    input  wire logic               set_cts_n,
    output logic [LEVEL_W-1:0]      tx_fifo_level = '0,
    output logic [LEVEL_W-1:0]      rx_fifo_level = '0,
    output logic                    tx_shift_busy = 1'b0,
    output logic                    line_idle = 1'b1,
    output logic                    clear_to_send_n_pin = 1'b1
);
    always @(posedge aclk) begin
        tx_fifo_level <= (!fifo_enable && set_tx > 1) ? LEVEL_W'(1) : set_tx;
        rx_fifo_level <= (!fifo_enable && set_rx > 1) ? LEVEL_W'(1) : set_rx;
        tx_shift_busy <= set_busy;
        line_idle <= set_idle;
        clear_to_send_n_pin <= set_cts_n;
    end
endmodule
`default_nettype wire
